// [inc/fdsp_regs.svh]
// Purpose: Constants for the fiber diagnostic status port.
// Assumes: Included by its bare name from the design file.
// Notes:   Bit positions refer to the 16-bit status word, the 8-bit control byte and the 4-bit switch banks.
`ifndef FDSP_REGS_SVH
`define FDSP_REGS_SVH

`define FDSP_ST_FLT_A     0
`define FDSP_ST_FLT_B     1
`define FDSP_ST_ROT_LO    8
`define FDSP_ST_ROT_HI    11
`define FDSP_ST_WORD_RST  16'h0000
`define FDSP_SWA_WR_EN    1
`define FDSP_SWB_FORCE_A  2
`define FDSP_SWB_FORCE_B  3
`define FDSP_CTL_FORCE_A  0
`define FDSP_CTL_FORCE_B  1
`define FDSP_CTL_RST      8'h00
`define FDSP_CHAN_RST     2'h0

`endif

// [inc/fdsp_pkg.sv]
// Purpose: Types for the fiber diagnostic status port.
// Assumes: Compiled before the design file.
// Notes:   Presentation codes are one-hot.
package fdsp_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} fdsp_scan_s;

	typedef enum logic [3:0] {
		FDSP_EMPTY  = 4'b0001,
		FDSP_IN8    = 4'b0010,
		FDSP_BIDIR8 = 4'b0100,
		FDSP_IN16   = 4'b1000
	} fdsp_pres_e;

	typedef struct packed {
		logic [1:0] contact;
		logic [1:0] tx_off;
	} fdsp_chan_s;

endpackage

// [hw/fdsp_top.sv]
// Purpose: Diagnostic status port of a two-channel redundant fiber module.
// Assumes: All inputs synchronous to mclk; the scan strobes are single-cycle pulses.
// Notes:   One block serves the standalone contacts and both backplane variants.
// Functional notes
// (RQ1) Each channel contact is normally open and closes while that channel errs.
// (RQ2) Two independent contacts, one per optical channel.
// (RQ3) Narrow variant shows as 8-bit bidirectional if writes enabled, else input-only.
// (RQ4) Control byte is writable only while switch bank A position 2 is on; the code gates writes with position 1 (FDSP_SWA_WR_EN).
// (RQ5) Diagnostics controlled both from the control byte and from the switches.
// (RQ6) Wide variant shows one 16-bit read-only status word.
// (RQ7) Without the diagnostic option the wide variant shows as an empty slot.
// (RQ8) Wide variant takes control only from switches, with no write path.
// (RQ9) Status bits read 0 when normal, 1 when asserted.
// (RQ10) Bits 11 to 8 hold the inverted rotary priority position.
// (RQ11) Status bit 0 is channel A receive fault, bit 1 channel B.
// (RQ12) A receive failure raises that channel's fault and disables its transmitter.
// (RQ13) Undefined status bits read zero; indications come from registered fault state.
`timescale 1ns/1ps
`include "fdsp_regs.svh"

module fdsp_top (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire logic              ce,
	input  wire logic              variant_16,
	input  wire logic              diag_present,
	input  wire logic [1:0]        rx_fault,
	input  wire logic [3:0]        sw_bank_a,
	input  wire logic [3:0]        sw_bank_b,
	input  wire logic [3:0]        priority_rotary_selector,
	input  wire fdsp_pkg::fdsp_scan_s scan,
	output logic [15:0]            rdata_ff,
	output logic                   rvalid_ff,
	output fdsp_pkg::fdsp_pres_e   pres_ff,
	output logic [7:0]             ctrl_ff,
	output fdsp_pkg::fdsp_chan_s   chan_ff
);
	import fdsp_pkg::*;

	// Builds the read image; the narrow variant has no rotary field.
	function automatic logic [15:0] fdsp_status(
		input logic [1:0] flt,
		input logic [3:0] rot,
		input logic       wide
	);
		logic [15:0] w;
		w = `FDSP_ST_WORD_RST; // RQ13
		w[`FDSP_ST_FLT_A] = flt[0]; // RQ11 RQ9
		w[`FDSP_ST_FLT_B] = flt[1]; // RQ11 RQ9
		if (wide) begin
			w[`FDSP_ST_ROT_HI:`FDSP_ST_ROT_LO] = ~rot; // RQ10
		end
		return w;
	endfunction

	// Presentation to the controller scan.
	fdsp_pres_e nxt_pres;

	always_comb begin
		if (!diag_present) begin
			nxt_pres = FDSP_EMPTY; // RQ7
		end else if (variant_16) begin
			nxt_pres = FDSP_IN16; // RQ6
		end else if (sw_bank_a[`FDSP_SWA_WR_EN]) begin
			nxt_pres = FDSP_BIDIR8; // RQ3
		end else begin
			nxt_pres = FDSP_IN8; // RQ3
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pres_ff <= FDSP_EMPTY;
		end else if (ce) begin
			pres_ff <= nxt_pres;
		end
	end

	// Control byte, written by the scan only in the bidirectional presentation.
	logic [7:0] nxt_ctrl;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (scan.wr && pres_ff == FDSP_BIDIR8 && sw_bank_a[`FDSP_SWA_WR_EN]) begin
			nxt_ctrl = scan.wdata; // RQ4 RQ8
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_ff <= `FDSP_CTL_RST;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Channel state: contacts follow receive faults; transmitters also obey forcing.
	fdsp_chan_s nxt_chan;
	logic [1:0] force_err;

	always_comb begin
		force_err[0] = sw_bank_b[`FDSP_SWB_FORCE_A]; // RQ5
		force_err[1] = sw_bank_b[`FDSP_SWB_FORCE_B]; // RQ5
		if (pres_ff == FDSP_BIDIR8) begin
			force_err[0] = force_err[0] | ctrl_ff[`FDSP_CTL_FORCE_A]; // RQ5
			force_err[1] = force_err[1] | ctrl_ff[`FDSP_CTL_FORCE_B]; // RQ5
		end
		nxt_chan.contact = rx_fault; // RQ1 RQ2 RQ12
		nxt_chan.tx_off  = rx_fault | force_err; // RQ12
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			chan_ff <= '{contact: `FDSP_CHAN_RST, tx_off: `FDSP_CHAN_RST};
		end else if (ce) begin
			chan_ff <= nxt_chan;
		end
	end

	// Scan read: snapshot of the status image, answered the next cycle.
	logic [15:0] nxt_rdata;
	logic        nxt_rvalid;

	always_comb begin
		nxt_rdata  = rdata_ff;
		nxt_rvalid = 1'b0;
		if (scan.rd && pres_ff != FDSP_EMPTY) begin
			nxt_rdata  = fdsp_status(chan_ff.contact, priority_rotary_selector,
				pres_ff == FDSP_IN16); // RQ13 RQ6
			nxt_rvalid = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_ff  <= `FDSP_ST_WORD_RST;
			rvalid_ff <= 1'b0;
		end else if (ce) begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking

	default disable iff (srst);

	contact_follows_rx_a: assert property ( // RQ1
		ce && rx_fault[0] && !rx_fault[1] |=> chan_ff.contact == 2'h1
	) else $error("contact does not follow receive fault");

	contacts_separate_a: assert property ( // RQ2
		ce && !rx_fault[0] && rx_fault[1] |=> chan_ff.contact == 2'h2
	) else $error("channel contacts not independent");

	tx_disable_fault_a: assert property ( // RQ12
		ce && rx_fault[1] |=> chan_ff.tx_off[1] && chan_ff.contact[1]
	) else $error("failed channel transmitter not disabled");

	switch_force_a: assert property ( // RQ5
		ce && sw_bank_b[`FDSP_SWB_FORCE_A] |=> chan_ff.tx_off[0]
	) else $error("switch force ignored");

	byte_force_a: assert property ( // RQ5
		ce && pres_ff == FDSP_BIDIR8 && ctrl_ff[`FDSP_CTL_FORCE_B] |=> chan_ff.tx_off[1]
	) else $error("control byte force ignored");

	write_locked_a: assert property ( // RQ4
		ce && scan.wr && !sw_bank_a[`FDSP_SWA_WR_EN] |=> $stable(ctrl_ff)
	) else $error("control byte written while locked");

	write_taken_a: assert property ( // RQ4
		ce && scan.wr && pres_ff == FDSP_BIDIR8 && sw_bank_a[`FDSP_SWA_WR_EN]
		|=> ctrl_ff == $past(scan.wdata)
	) else $error("enabled write not taken");

	wide_no_write_a: assert property ( // RQ8
		pres_ff == FDSP_IN16 ##1 pres_ff == FDSP_IN16 |-> $stable(ctrl_ff)
	) else $error("wide variant control changed by scan");

	pres_bidir_a: assert property ( // RQ3
		ce && diag_present && !variant_16 && sw_bank_a[`FDSP_SWA_WR_EN]
		|=> pres_ff == FDSP_BIDIR8
	) else $error("narrow variant not bidirectional");

	pres_input_a: assert property ( // RQ3
		ce && diag_present && !variant_16 && !sw_bank_a[`FDSP_SWA_WR_EN]
		|=> pres_ff == FDSP_IN8
	) else $error("narrow variant not input-only");

	empty_slot_a: assert property ( // RQ7
		ce && !diag_present |=> pres_ff == FDSP_EMPTY
	) else $error("absent option not an empty slot");

	empty_read_a: assert property ( // RQ7
		ce && scan.rd && pres_ff == FDSP_EMPTY |=> !rvalid_ff
	) else $error("empty slot answered a read");

	rotary_field_a: assert property ( // RQ10
		ce && scan.rd && pres_ff == FDSP_IN16
		|=> rvalid_ff && rdata_ff[`FDSP_ST_ROT_HI:`FDSP_ST_ROT_LO]
			== ~$past(priority_rotary_selector)
	) else $error("rotary field not inverted position");

	fault_bits_a: assert property ( // RQ11
		ce && scan.rd && pres_ff != FDSP_EMPTY
		|=> rdata_ff[`FDSP_ST_FLT_B:`FDSP_ST_FLT_A] == $past(chan_ff.contact)
	) else $error("fault bits wrong");

	undef_zero_a: assert property ( // RQ13
		rvalid_ff |-> rdata_ff[15:12] == 4'h0 && rdata_ff[7:2] == 6'h00
	) else $error("undefined status bits not zero");

	narrow_no_rot_a: assert property ( // RQ13
		rvalid_ff && pres_ff != FDSP_IN16 && $past(pres_ff) != FDSP_IN16
		|-> rdata_ff[`FDSP_ST_ROT_HI:`FDSP_ST_ROT_LO] == 4'h0
	) else $error("narrow status byte carries rotary bits");

	// Contacts open again on the clock edge after a channel's receive fault clears.
	contact_a_open_a: assert property ( // RQ1
		ce && !rx_fault[0] |=> !chan_ff.contact[0]
	) else $error("channel A contact stuck closed");

	contact_b_open_a: assert property ( // RQ2
		ce && !rx_fault[1] |=> !chan_ff.contact[1]
	) else $error("channel B contact stuck closed");

	// Forcing disturbs only the transmitters; the contacts keep reporting real faults.
	force_no_contact_a: assert property ( // RQ1
		ce && !rx_fault[0] && sw_bank_b[`FDSP_SWB_FORCE_A] |=> !chan_ff.contact[0]
	) else $error("forced error closed a contact");

	both_contacts_a: assert property ( // RQ2
		ce && rx_fault == 2'h3 |=> chan_ff.contact == 2'h3
	) else $error("both contacts not closed");

	tx_a_fault_a: assert property ( // RQ12
		ce && rx_fault[0] |=> chan_ff.tx_off[0] && chan_ff.contact[0]
	) else $error("channel A transmitter not disabled");

	// With no fault and no force source a transmitter must stay enabled.
	tx_a_idle_a: assert property ( // RQ12
		ce && !rx_fault[0] && !sw_bank_b[`FDSP_SWB_FORCE_A]
		&& !(pres_ff == FDSP_BIDIR8 && ctrl_ff[`FDSP_CTL_FORCE_A]) |=> !chan_ff.tx_off[0]
	) else $error("channel A transmitter disabled without cause");

	tx_b_idle_a: assert property ( // RQ12
		ce && !rx_fault[1] && !sw_bank_b[`FDSP_SWB_FORCE_B]
		&& !(pres_ff == FDSP_BIDIR8 && ctrl_ff[`FDSP_CTL_FORCE_B]) |=> !chan_ff.tx_off[1]
	) else $error("channel B transmitter disabled without cause");

	switch_force_b_a: assert property ( // RQ5
		ce && sw_bank_b[`FDSP_SWB_FORCE_B] |=> chan_ff.tx_off[1]
	) else $error("switch force B ignored");

	byte_force_first_a: assert property ( // RQ5
		ce && pres_ff == FDSP_BIDIR8 && ctrl_ff[`FDSP_CTL_FORCE_A] |=> chan_ff.tx_off[0]
	) else $error("control byte force A ignored");

	// Outside the bidirectional presentation a stored control byte has no effect.
	wide_byte_ignored_a: assert property ( // RQ8
		ce && pres_ff != FDSP_BIDIR8 && !rx_fault[1] && !sw_bank_b[`FDSP_SWB_FORCE_B]
		|=> !chan_ff.tx_off[1]
	) else $error("control byte acted outside bidirectional mode");

	wide_write_ignored_a: assert property ( // RQ8
		ce && scan.wr && pres_ff == FDSP_IN16 |=> $stable(ctrl_ff)
	) else $error("wide variant took a write");

	input_write_ignored_a: assert property ( // RQ3
		ce && scan.wr && pres_ff == FDSP_IN8 |=> $stable(ctrl_ff)
	) else $error("input-only variant took a write");

	pres_wide_a: assert property ( // RQ6
		ce && diag_present && variant_16 |=> pres_ff == FDSP_IN16
	) else $error("wide variant not a 16-bit input");

	pres_onehot_a: assert property ( // RQ3
		$onehot(pres_ff)
	) else $error("presentation code not one-hot");

	wide_read_valid_a: assert property ( // RQ6
		ce && scan.rd && pres_ff == FDSP_IN16 |=> rvalid_ff
	) else $error("wide read not answered");

	narrow_read_valid_a: assert property ( // RQ3
		ce && scan.rd && (pres_ff == FDSP_IN8 || pres_ff == FDSP_BIDIR8)
		|=> rvalid_ff && rdata_ff[`FDSP_ST_ROT_HI:`FDSP_ST_ROT_LO] == 4'h0
	) else $error("narrow read not answered cleanly");

	// The read answer is a single-cycle pulse.
	rvalid_pulse_a: assert property ( // RQ13
		ce && !scan.rd |=> !rvalid_ff
	) else $error("read valid without a read");

	rdata_hold_a: assert property ( // RQ13
		ce && !(scan.rd && pres_ff != FDSP_EMPTY)
		|=> $stable(rdata_ff)
	) else $error("read data changed without a read");

	// A low clock enable freezes every register of the block unless srst is high.
	freeze_all_a: assert property ( // RQ13
		!ce |=> $stable(chan_ff) && $stable(ctrl_ff) && $stable(pres_ff)
		&& $stable(rdata_ff)
		&& $stable(rvalid_ff)
	) else $error("state moved while clock enable low");

endmodule

// [tb/fdsp_scan_model.sv]
// Purpose: Controller I/O scan that reads and writes the diagnostic port.
// Assumes: Strobes change just after a rising mclk edge.
// Notes:   Released write data shows the inverse of the last byte.
`timescale 1ns/1ps
module fdsp_scan_model (
	input  wire logic          mclk,
	input  wire logic          rvalid,
	input  wire logic [15:0]   rdata,
	output fdsp_pkg::fdsp_scan_s scan
);
	import fdsp_pkg::*;
	initial scan = '0;
	task automatic rd(output logic [16:0] res);
		@(posedge mclk);
		scan.rd <= 1'b1;
		@(posedge mclk);
		scan.rd <= 1'b0;
		#1;
		res = {rvalid, rdata};
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge mclk);
		scan.wr    <= 1'b1;
		scan.wdata <= d;
		@(posedge mclk);
		scan.wr    <= 1'b0;
		scan.wdata <= ~d;
	endtask
endmodule

// [tb/fdsp_top_tb.sv]
// Purpose: Self-checking bench for the diagnostic status port.
// Assumes: Scan model drives all scan strobes.
// Notes:   Expected images come from the status word layout.
`timescale 1ns/1ps
module fdsp_top_tb;
	import fdsp_pkg::*;
	logic        mclk = 1'b0, srst = 1'b1, dp = 1'b1, v16 = 1'b0, ce = 1'b1;
	logic [1:0]  rxf = 2'h0;
	logic [3:0]  swa = 4'h0, swb = 4'h0, rot = 4'h0;
	logic [15:0] rdata;
	logic        rvalid;
	logic [7:0]  ctrl;
	logic [16:0] r;
	fdsp_scan_s  scan;
	fdsp_pres_e  pres, e;
	fdsp_chan_s  chan;
	int          errors = 0, tests_run = 0;
	initial forever #4 mclk = ~mclk;
	fdsp_scan_model sm (.mclk(mclk), .rvalid(rvalid), .rdata(rdata), .scan(scan));
	fdsp_top dut (.mclk(mclk), .srst(srst), .ce(ce), .variant_16(v16),
		.diag_present(dp), .rx_fault(rxf), .sw_bank_a(swa), .sw_bank_b(swb),
		.priority_rotary_selector(rot), .scan(scan), .rdata_ff(rdata),
		.rvalid_ff(rvalid), .pres_ff(pres), .ctrl_ff(ctrl), .chan_ff(chan));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic setup(input logic w16, input logic en);
		v16 <= w16;
		swa <= {2'b00, en, 1'b0};
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic t_pres;
		for (int i = 0; i < 8; i++) begin
			dp <= i[2];
			setup(i[1], i[0]);
			e = !dp ? FDSP_EMPTY : v16 ? FDSP_IN16 : i[0] ? FDSP_BIDIR8 : FDSP_IN8;
			chk(pres, e);
		end
		sm.rd(r);
		chk(r[16], 1'b1);
		dp <= 1'b0;
		setup(1'b1, 1'b0);
		sm.rd(r);
		chk(r[16], 1'b0);
		dp <= 1'b1;
	endtask
	task automatic t_status;
		setup(1'b1, 1'b0);
		for (int i = 0; i < 10; i++) begin
			rot <= i[3:0];
			rxf <= i[1:0];
			repeat (2) @(posedge mclk);
			sm.rd(r);
			chk(r, {1'b1, 4'h0, ~i[3:0], 6'h00, i[1:0]});
			chk(chan, {i[1:0], i[1:0]});
		end
		@(posedge mclk);
		#1;
		chk(rvalid, 1'b0);
		rxf <= 2'h0;
	endtask
	task automatic t_write;
		setup(1'b0, 1'b1);
		sm.wr(8'h03);
		@(posedge mclk);
		#1;
		chk({ctrl, chan}, 12'h033);
		sm.wr(8'h00);
		swb <= 4'hC;
		repeat (2) @(posedge mclk);
		#1;
		chk(chan, 4'h3);
		swb <= 4'h0;
		setup(1'b0, 1'b0);
		sm.wr(8'h01);
		#1;
		chk(ctrl, 8'h00);
		setup(1'b1, 1'b1);
		sm.wr(8'h02);
		#1;
		chk(ctrl, 8'h00);
	endtask
	task automatic t_freeze;
		setup(1'b0, 1'b0);
		ce  <= 1'b0;
		rxf <= 2'h3;
		rot <= 4'h5;
		repeat (2) @(posedge mclk);
		#1;
		chk(chan, 4'h0);
		sm.rd(r);
		chk(r[16], 1'b0);
		ce <= 1'b1;
		repeat (2) @(posedge mclk);
		sm.rd(r);
		chk(r, 17'h10003);
		chk(chan, 4'hF);
		rxf <= 2'h0;
		rot <= 4'h0;
	endtask
	task automatic finish_test;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		t_pres();
		t_status();
		t_write();
		t_freeze();
		finish_test();
	end
endmodule
